// ### src/lcd_seg_pkg.sv
/*
 * lcd_seg_pkg: register map, field positions, reset values and timing
 * constants of the segment display controller.
 * Assumes an APB slave with 32-bit data and word-aligned registers.
 */
package lcd_seg_pkg;

    // register byte offsets
    localparam logic [11:0] off_control     = 12'h000;
    localparam logic [11:0] off_prescaler   = 12'h004;
    localparam logic [11:0] off_com_enable  = 12'h008;
    localparam logic [11:0] off_seg_low     = 12'h00c;
    localparam logic [11:0] off_seg_high    = 12'h010;
    localparam logic [11:0] off_blink       = 12'h014;
    localparam logic [11:0] off_ram_base    = 12'h020;
    localparam int          ram_words       = 10;

    // field positions in the control word; source select in the prescaler
    localparam int bit_timer_run   = 6;
    localparam int bit_drive_power_source_select        = 5;
    localparam int bit_ms_lo       = 2;
    localparam int bit_divider_resistor_value        = 13;
    localparam int bit_bias8       = 12;
    localparam int bit_inv         = 11;
    localparam int bit_blank       = 10;
    localparam int bit_irq_en      = 9;
    localparam int bit_irq_flag    = 8;
    localparam int bit_port_input_control       = 23;
    localparam int bit_blink_interval_select       = 22;
    localparam int bit_ve_lo       = 17;
    localparam int bit_source_clock_select      = 22;

    // writable masks and reset values
    localparam logic [31:0] control_mask    = 32'h00fe_3f7c;
    localparam logic [31:0] control_reset   = 32'h003e_1400;
    localparam logic [31:0] prescaler_mask  = 32'h007f_ffff;
    localparam logic [31:0] com_mask        = 32'h0000_00ff;
    localparam logic [31:0] seg_high_mask   = 32'h0000_00ff;
    localparam logic [31:0] blink_mask      = 32'h0000_ffff;

    // blink divider exponents of the sub-clock
    localparam int blink_exp_short = 14;
    localparam int blink_exp_long  = 15;

    typedef enum logic [2:0] {
        mode_stop, mode_com4_d2, mode_com4_d3, mode_com4_d4, mode_com8
    } disp_mode_t;

    typedef struct packed {
        logic        timer_run;
        logic        drive_power_source_select;
        logic [2:0]  ms;
        logic        divider_resistor_value;
        logic        bias8;
        logic        reverse_display;
        logic        blank;
        logic        irq_en;
        logic        port_input_control;
        logic        blink_interval_select;
        logic [4:0]  ve;
        logic        source_clock_select;
        logic [21:0] clock_division_ratio;
    } cfg_t;

endpackage

// ### src/lcd_segment_drive_control.sv
/*
 * lcd_segment_drive_control: registers, clock prescaler, frame sequencer,
 * blink timer and pin assignment of a segment display driver.
 * Assumes APB access, sub_clk_en as a one-cycle enable at the sub-clock
 * rate, and an analog stage that turns the drive codes into voltages.
 */
// The placing of the registers and the APB slave port were chosen for this implementation.
// Functional notes
// - mode field picks stop, 4-com duties, 8-com
// - timer-mode run bit keeps sequencer alive
// - drive source selects internal or external dividers
// - resistor bit picks 100k or 10k
// - bias bit 1/3 or 1/4, 8-com only
// - reverse bit inverts displayed pattern
// - blank bit shows blank, resets to one
// - enable gates request; flag shows detection
// - port input control cuts inputs when clear
// - enabled com/seg pins keep inputs cut
// - blink period sub-clock over 2^14 or 2^15
// - five drive pin selects, reset to one
// - drive pin selects unchanged by internal dividers
// - source select: sub-clock or bus clock
// - 22-bit divider divides by value plus one
// - eight com enables close switches
// - upper com enables only close switches in 4-com, no segment data
// - forty segment enables close switches
// - reserved bits read zero, ignore writes
// - sixteen blink bits pick blinking dots
// - two-frame alternating waveform, no net DC
// - cycle end sets flag; write zero clears
// - memory one gives selected segment level
`timescale 1ns/1ps
module lcd_segment_drive_control (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        sub_clk_en,
    input  wire logic        timer_mode,
    input  wire logic [43:0] pad_in,
    output logic      [43:0] pad_in_gated,
    output logic      [7:0]  com_switch,
    output logic      [39:0] seg_switch,
    output logic      [4:0]  drive_pin_select,
    output logic             divider_internal,
    output logic             divider_10k,
    output logic      [2:0]  bias_level,
    output logic      [7:0]  com_select,
    output logic      [43:0] seg_on,
    output logic             frame_phase,
    output logic             irq
);

    lcd_seg_pkg::cfg_t cfg_q;
    logic        irq_flag_q;
    logic [31:0] com_en_q;
    logic [31:0] seg_lo_q;
    logic [31:0] seg_hi_q;
    logic [31:0] blink_q;
    logic [31:0] ram_q [lcd_seg_pkg::ram_words];
    logic [21:0] div_cnt_q;
    logic [2:0]  com_idx_q;
    logic        frame_q;
    logic [15:0] blink_cnt_q;
    logic        blink_off_q;
    logic        wr_en;
    logic        rd_en;
    logic [31:0] rdata_d;
    logic        hit_d;
    logic        cycle_end;
    logic        lcd_tick;
    logic        src_en;
    logic        running;
    logic        com8;
    logic [2:0]  last_com;
    logic [31:0] ctrl_view;
    logic [31:0] psr_view;
    logic [43:0] seg_d;
    logic [43:0] seg_en_all;

    // every access completes on the first access cycle
    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && penable && !pwrite;

    assign com8     = cfg_q.ms[2];
    assign last_com = com8 ? 3'h7 : (cfg_q.ms[1:0] == 2'h1 ? 3'h1 :
                      (cfg_q.ms[1:0] == 2'h2 ? 3'h2 : 3'h3));
    // halted in timer mode unless the run bit is set
    assign running  = (cfg_q.ms != 3'h0) && (!timer_mode || cfg_q.timer_run);

    // packed views, reserved bits forced to zero
    assign ctrl_view = {8'h00, cfg_q.port_input_control, cfg_q.blink_interval_select, cfg_q.ve, 1'b0,
                        2'b00, cfg_q.divider_resistor_value, cfg_q.bias8, cfg_q.reverse_display, cfg_q.blank,
                        cfg_q.irq_en, irq_flag_q,
                        1'b0, cfg_q.timer_run, cfg_q.drive_power_source_select, cfg_q.ms, 2'b00};
    assign psr_view  = {9'h000, cfg_q.source_clock_select, cfg_q.clock_division_ratio};

    // control and prescaler registers; writable at any time
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            // blank, bias and drive pin selects reset to one
            cfg_q <= '{ms: 3'h0, clock_division_ratio: 22'h000000, ve: 5'h1f,
                       bias8: 1'b1, blank: 1'b1, default: 1'b0};
        end
        else if (wr_en && paddr == lcd_seg_pkg::off_control)
        begin
            cfg_q.timer_run <= pwdata[lcd_seg_pkg::bit_timer_run];
            cfg_q.drive_power_source_select      <= pwdata[lcd_seg_pkg::bit_drive_power_source_select];
            cfg_q.ms        <= pwdata[lcd_seg_pkg::bit_ms_lo +: 3];
            cfg_q.divider_resistor_value      <= pwdata[lcd_seg_pkg::bit_divider_resistor_value];
            cfg_q.bias8     <= pwdata[lcd_seg_pkg::bit_bias8];
            cfg_q.reverse_display       <= pwdata[lcd_seg_pkg::bit_inv];
            cfg_q.blank     <= pwdata[lcd_seg_pkg::bit_blank];
            cfg_q.irq_en    <= pwdata[lcd_seg_pkg::bit_irq_en];
            cfg_q.port_input_control     <= pwdata[lcd_seg_pkg::bit_port_input_control];
            cfg_q.blink_interval_select     <= pwdata[lcd_seg_pkg::bit_blink_interval_select];
            cfg_q.ve        <= pwdata[lcd_seg_pkg::bit_ve_lo +: 5];
        end
        else if (wr_en && paddr == lcd_seg_pkg::off_prescaler)
        begin
            cfg_q.source_clock_select <= pwdata[lcd_seg_pkg::bit_source_clock_select];
            cfg_q.clock_division_ratio <= pwdata[21:0];
        end
    end

    // flag set on cycle end wins over a software clear
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            irq_flag_q <= 1'b0;
        else if (cycle_end)
            irq_flag_q <= 1'b1;
        else if (wr_en && paddr == lcd_seg_pkg::off_control
                 && !pwdata[lcd_seg_pkg::bit_irq_flag])
            irq_flag_q <= 1'b0;
    end

    // pin-assignment and blink registers, reserved bits masked
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            com_en_q <= 32'h0000_0000;
            seg_lo_q <= 32'h0000_0000;
            seg_hi_q <= 32'h0000_0000;
            blink_q  <= 32'h0000_0000;
        end
        else if (wr_en)
        begin
            if (paddr == lcd_seg_pkg::off_com_enable)
                com_en_q <= pwdata & lcd_seg_pkg::com_mask;
            else if (paddr == lcd_seg_pkg::off_seg_low)
                seg_lo_q <= pwdata;
            else if (paddr == lcd_seg_pkg::off_seg_high)
                seg_hi_q <= pwdata & lcd_seg_pkg::seg_high_mask;
            else if (paddr == lcd_seg_pkg::off_blink)
                blink_q <= pwdata & lcd_seg_pkg::blink_mask;
        end
    end

    // display memory, one word per four segment bytes
    genvar gi;
    generate
        for (gi = 0; gi < lcd_seg_pkg::ram_words; gi++)
        begin : g_ram
            always_ff @(posedge clk or posedge rst)
            begin
                if (rst)
                    ram_q[gi] <= 32'h0000_0000;
                else if (wr_en && paddr == lcd_seg_pkg::off_ram_base + 12'(4 * gi))
                    ram_q[gi] <= pwdata;
            end
        end
    endgenerate

    // read decode; unmapped addresses answer zero with an error
    always_comb
    begin
        rdata_d = 32'h0000_0000;
        hit_d   = 1'b1;
        if (paddr == lcd_seg_pkg::off_control)
            rdata_d = ctrl_view;
        else if (paddr == lcd_seg_pkg::off_prescaler)
            rdata_d = psr_view;
        else if (paddr == lcd_seg_pkg::off_com_enable)
            rdata_d = com_en_q;
        else if (paddr == lcd_seg_pkg::off_seg_low)
            rdata_d = seg_lo_q;
        else if (paddr == lcd_seg_pkg::off_seg_high)
            rdata_d = seg_hi_q;
        else if (paddr == lcd_seg_pkg::off_blink)
            rdata_d = blink_q;
        else if (paddr >= lcd_seg_pkg::off_ram_base && paddr[1:0] == 2'b00 &&
                 paddr < lcd_seg_pkg::off_ram_base + 12'(4 * lcd_seg_pkg::ram_words))
            rdata_d = ram_q[4'((paddr - lcd_seg_pkg::off_ram_base) >> 2)];
        else
            hit_d = 1'b0;
    end

    // bus answer registered in the setup cycle, ready on the access cycle
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !hit_d;
            prdata  <= (psel && !penable && !pwrite) ? rdata_d : 32'h0000_0000;
        end
    end

    // source enable; bus clock is every cycle here
    assign src_en   = cfg_q.source_clock_select ? 1'b1 : sub_clk_en;
    // tick after clock_division_ratio+1 source pulses; a count already past a newly
    // lowered ratio ends the period at once instead of wrapping 2^22 pulses
    assign lcd_tick = src_en && (div_cnt_q >= cfg_q.clock_division_ratio);

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            div_cnt_q <= 22'h000000;
        else if (!running)
            div_cnt_q <= 22'h000000;
        else if (src_en)
            div_cnt_q <= lcd_tick ? 22'h000000 : div_cnt_q + 22'h000001;
    end

    // commons step each tick; frame polarity toggles per scan
    assign cycle_end = running && lcd_tick && (com_idx_q == last_com) && frame_q;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            com_idx_q <= 3'h0;
            frame_q   <= 1'b0;
        end
        else if (!running)
        begin
            com_idx_q <= 3'h0;
            frame_q   <= 1'b0;
        end
        else if (lcd_tick)
        begin
            if (com_idx_q >= last_com)
            begin
                com_idx_q <= 3'h0;
                frame_q   <= !frame_q;
            end
            else
                com_idx_q <= com_idx_q + 3'h1;
        end
    end

    // blink timer on the sub-clock, 2^14 or 2^15 pulses
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            blink_cnt_q <= 16'h0000;
            blink_off_q <= 1'b0;
        end
        else if (sub_clk_en)
        begin
            if (blink_cnt_q >= (cfg_q.blink_interval_select ? 16'((32'h1 << lcd_seg_pkg::blink_exp_long) - 1)
                                : 16'((32'h1 << lcd_seg_pkg::blink_exp_short) - 1)))
            begin
                blink_cnt_q <= 16'h0000;
                blink_off_q <= !blink_off_q;
            end
            else
                blink_cnt_q <= blink_cnt_q + 16'h0001;
        end
    end

    // segment data for the active common
    always_comb
    begin
        seg_d = '0;
        for (int s = 0; s < 44; s++)
        begin
            if (com8)
                seg_d[s] = (s < 40) ? ram_q[s / 4][(s % 4) * 8 + int'(com_idx_q)] : 1'b0;
            else
                seg_d[s] = (s < 40) ? ram_q[s / 8][(s % 8) * 4 + int'(com_idx_q[1:0])]
                                    : 1'b0;
            // blinking dot dark during the off half
            if (blink_off_q && com8 && s < 2 && blink_q[s * 8 + int'(com_idx_q)])
                seg_d[s] = 1'b0;
            if (blink_off_q && !com8 && s < 4 && blink_q[s * 4 + int'(com_idx_q[1:0])])
                seg_d[s] = 1'b0;
            seg_d[s] = seg_d[s] ^ cfg_q.reverse_display;
            if (cfg_q.blank)
                seg_d[s] = 1'b0;
        end
    end

    assign seg_en_all = {4'h0, seg_hi_q[7:0], seg_lo_q};

    // drive outputs, all registered
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            seg_on       <= '0;
            com_select   <= 8'h00;
            frame_phase  <= 1'b0;
            bias_level   <= 3'h0;
            irq          <= 1'b0;
        end
        else
        begin
            seg_on      <= running ? seg_d : '0;
            com_select  <= running ? 8'(1 << com_idx_q) : 8'h00;
            // polarity drops with the commons so both move on the same edge
            frame_phase <= running ? frame_q : 1'b0;
            // bias denominator; 1/2 duty uses 1/2 bias
            bias_level  <= com8 ? (cfg_q.bias8 ? 3'h4 : 3'h3)
                         : (cfg_q.ms[1:0] == 2'h1 ? 3'h2 : 3'h3);
            irq         <= irq_flag_q && cfg_q.irq_en;
        end
    end

    // pin assignment outputs
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            com_switch       <= 8'h00;
            seg_switch       <= '0;
            drive_pin_select <= 5'h1f;
            divider_internal <= 1'b0;
            divider_10k      <= 1'b0;
            pad_in_gated     <= '0;
        end
        else
        begin
            // upper com switches follow their enables in 4-com mode too
            com_switch       <= com_en_q[7:0];
            seg_switch       <= seg_en_all[39:0];
            // selects follow ve in both divider modes; top pin relied on
            drive_pin_select <= cfg_q.drive_power_source_select ? {cfg_q.ve[4], cfg_q.ve[3:0]} : cfg_q.ve;
            divider_internal <= cfg_q.drive_power_source_select;
            divider_10k      <= cfg_q.drive_power_source_select && cfg_q.divider_resistor_value;
            // input cut-off, enabled pins stay cut
            pad_in_gated     <= pad_in & {44{cfg_q.port_input_control}}
                              & ~{com_en_q[3:0], seg_en_all[39:0]};
        end
    end

endmodule

// ### testbench/lcd_drive_assertions.sv
/* port checker for the segment drive control block
   assumes the bind below, one clock, async active-high reset */
`timescale 1ns/1ps
module lcd_drive_checker (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        sub_clk_en,
    input wire logic        timer_mode,
    input wire logic [43:0] pad_in,
    input wire logic [43:0] pad_in_gated,
    input wire logic [7:0]  com_switch,
    input wire logic [39:0] seg_switch,
    input wire logic [4:0]  drive_pin_select,
    input wire logic        divider_internal,
    input wire logic        divider_10k,
    input wire logic [2:0]  bias_level,
    input wire logic [7:0]  com_select,
    input wire logic [43:0] seg_on,
    input wire logic        frame_phase,
    input wire logic        irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready held past one cycle");
    a_ready_access: assert property (psel && penable |-> pready)
        else $error("access cycle without ready");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("error outside an answer");
    a_data_idle: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside an answer");
    a_gated_subset: assert property ((pad_in_gated & ~$past(pad_in)) == 44'h0)
        else $error("gated input shows a level the pin lacked");
    a_gated_cut: assert property ($stable(seg_switch) && $stable(com_switch)
        |-> (pad_in_gated & {com_switch[3:0], seg_switch}) == 44'h0)
        else $error("input of a driven pin not cut");
    a_com_onehot: assert property ($onehot0(com_select))
        else $error("more than one common active");
    a_bias_range: assert property (!$past(rst) |-> bias_level inside {3'h2, 3'h3, 3'h4})
        else $error("bias outside two to four");
    a_pins_reset: assert property ($past(rst) |-> drive_pin_select == 5'h1f)
        else $error("drive pins not power after reset");
    a_phase_step: assert property ($changed(frame_phase) |-> $changed(com_select))
        else $error("frame polarity moved between commons");
endmodule

bind lcd_segment_drive_control lcd_drive_checker chk (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sub_clk_en(sub_clk_en), .timer_mode(timer_mode),
    .pad_in(pad_in), .pad_in_gated(pad_in_gated), .com_switch(com_switch),
    .seg_switch(seg_switch), .drive_pin_select(drive_pin_select),
    .divider_internal(divider_internal), .divider_10k(divider_10k),
    .bias_level(bias_level), .com_select(com_select), .seg_on(seg_on),
    .frame_phase(frame_phase), .irq(irq)
);

// ### testbench/lcd_panel_model.sv
/* passive panel and outside world on the shared pins
   assumes a pin with a closed switch carries analog drive, not logic */
`timescale 1ns/1ps
module lcd_panel_model (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [7:0]  com_switch,
    input  wire logic [39:0] seg_switch,
    input  wire logic [43:0] gpio_level,
    output logic      [43:0] pad_in
);
    logic        wobble_q;
    logic [43:0] driven;
    // a driven pin reads back as junk that flips every cycle, never a steady level
    always_ff @(posedge clk or posedge rst)
        if (rst)
            wobble_q <= 1'b0;
        else
            wobble_q <= ~wobble_q;
    // open pins show what the outside world applies
    assign driven = {com_switch[3:0], seg_switch};
    assign pad_in = (gpio_level & ~driven) | ({44{wobble_q}} & driven);
endmodule

// ### testbench/test_lcd_segment_drive_control.sv
/* self-checking bench for the segment drive control block
   assumes the bound checker and the panel model on the pins */
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin mismatches++; \
    $display("unexpected at %0t: %h not %h", $time, a, b); end end
module test_lcd_segment_drive_control;
    logic        clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, err;
    logic        pready, pslverr, sub_clk_en = 0, sub_on = 0, timer_mode = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd, c, v, s;
    logic [43:0] pad_in, pad_in_gated, seg_on, gpio = '0, seen;
    logic [7:0]  com_switch, com_select, cs;
    logic [39:0] seg_switch;
    logic [4:0]  drive_pin_select;
    logic [2:0]  bias_level;
    logic [1:0]  ph;
    logic        divider_internal, divider_10k, frame_phase, irq;
    int          mismatches = 0, compares = 0, n, g;
    localparam logic [31:0] base = 32'h003e_0000; // drive pins kept as power
    localparam logic [11:0] offs [6] = '{lcd_seg_pkg::off_control,
        lcd_seg_pkg::off_prescaler, lcd_seg_pkg::off_com_enable,
        lcd_seg_pkg::off_seg_low, lcd_seg_pkg::off_seg_high, lcd_seg_pkg::off_blink};
    localparam logic [31:0] msks [6] = '{lcd_seg_pkg::control_mask,
        lcd_seg_pkg::prescaler_mask, lcd_seg_pkg::com_mask, 32'hffff_ffff,
        lcd_seg_pkg::seg_high_mask, lcd_seg_pkg::blink_mask};

    always #2.5 clk = ~clk;
    // sub-clock enable every other cycle while sub_on is set
    always @(posedge clk) sub_clk_en <= sub_on & ~sub_clk_en;

    lcd_segment_drive_control dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sub_clk_en(sub_clk_en), .timer_mode(timer_mode),
        .pad_in(pad_in), .pad_in_gated(pad_in_gated), .com_switch(com_switch),
        .seg_switch(seg_switch), .drive_pin_select(drive_pin_select),
        .divider_internal(divider_internal), .divider_10k(divider_10k),
        .bias_level(bias_level), .com_select(com_select), .seg_on(seg_on),
        .frame_phase(frame_phase), .irq(irq));
    lcd_panel_model panel (.clk(clk), .rst(rst), .com_switch(com_switch),
        .seg_switch(seg_switch), .gpio_level(gpio), .pad_in(pad_in));

    // one transfer; ready, read data and error taken at the rising edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1 && ++k < 20);
        `CHK(pready, 1'b1)
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rchk(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK(rd, e)
    endtask
    // gather what the display shows over a span
    task automatic watch();
        seen = '0;
        cs = '0;
        ph = '0;
        @(negedge clk); // first sample still shows the old setting
        repeat (40)
        begin
            @(negedge clk);
            seen |= seg_on;
            cs |= com_select;
            ph |= 2'b01 << frame_phase;
        end
    endtask
    // cycles until the active common next moves, capped at 99
    task automatic chg();
        cs = com_select;
        g = 0;
        do begin @(negedge clk); g++; end while (com_select === cs && g < 99);
    endtask
    function automatic logic [2:0] exp_bias(input logic [2:0] m, input logic b8);
        return (m == 3'h1) ? 3'h2 : (m[2] && b8) ? 3'h4 : 3'h3;
    endfunction
    function automatic logic [7:0] exp_coms(input logic [2:0] m);
        return (m == 3'h0) ? 8'h00 : m[2] ? 8'hff : 8'((9'h2 << m) - 9'h1);
    endfunction
    task automatic final_report;
        $display("%0d compares, %0d mismatches", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial
    begin
        #(5ns * 90000);
        mismatches++;
        final_report;
    end

    initial
    begin
        void'($urandom(32'h0b1b485b));
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        `CHK(drive_pin_select, 5'h1f)
        for (int i = 0; i < 6; i++)
            rchk(offs[i], i == 0 ? lcd_seg_pkg::control_reset : 32'h0);
        for (int i = 1; i < 6; i++)
        begin
            v = $urandom;
            if (i == 2)
                c = v;
            apb(1'b1, offs[i], v);
            rchk(offs[i], v & msks[i]);
        end
        `CHK(com_switch, c[7:0])
        v = $urandom & 32'hffff_feff;
        // top drive pin kept as power with internal dividers
        v[21] = v[21] | v[5];
        apb(1'b1, offs[0], v);
        apb(1'b0, offs[0], 32'h0);
        `CHK(rd & 32'hffff_feff, v & lcd_seg_pkg::control_mask)
        `CHK(drive_pin_select, v[21:17])
        `CHK(divider_internal, v[5])
        if (v[5])
            `CHK(divider_10k, v[13])
        apb(1'b1, 12'h018, 32'hffff_ffff);
        `CHK(err, 1'b1)
        rchk(12'h018, 32'h0);
        $display("test registers done");
        apb(1'b1, offs[5], 32'h0);
        apb(1'b1, offs[1], 32'h0040_0000);
        for (int m = 0; m < 16; m++)
        begin
            apb(1'b1, offs[0], base | 32'({m[3], 7'h0, m[2:0], 2'h0}));
            watch();
            `CHK(bias_level, exp_bias(m[2:0], m[3]))
            `CHK(cs, exp_coms(m[2:0]))
        end
        $display("test modes done");
        apb(1'b1, offs[0], base | 32'h10);
        repeat (3)
        begin
            n = $urandom_range(5);
            apb(1'b1, offs[1], 32'h0040_0000 | n);
            repeat (2) chg();
            chg();
            `CHK(g, n + 1)
        end
        apb(1'b1, offs[1], 32'h0);
        repeat (3) chg();
        `CHK(g, 99)
        @(posedge clk);
        sub_on <= 1'b1;
        repeat (2) chg();
        `CHK(g, 2)
        @(posedge clk);
        timer_mode <= 1'b1;
        repeat (3) chg();
        `CHK(g, 99)
        apb(1'b1, offs[0], base | 32'h50);
        repeat (3) chg();
        `CHK(g, 2)
        @(posedge clk);
        timer_mode <= 1'b0;
        $display("test clocking done");
        for (int i = 0; i < 10; i++)
            apb(1'b1, lcd_seg_pkg::off_ram_base + 12'(4 * i), 32'hffff_ffff);
        apb(1'b1, offs[3], 32'hffff_ffff);
        apb(1'b1, offs[4], 32'hff);
        apb(1'b1, offs[1], 32'h0040_0000);
        apb(1'b1, offs[0], base | 32'h410);
        watch();
        `CHK(seen, 44'h0)
        apb(1'b1, offs[0], base | 32'h10);
        watch();
        `CHK(seen[39:0], 40'hff_ffff_ffff)
        `CHK(ph, 2'b11)
        apb(1'b1, offs[0], base | 32'h810);
        watch();
        `CHK(seen[39:0], 40'h0)
        $display("test display done");
        apb(1'b1, offs[0], base | 32'h204);
        n = 0;
        while (irq !== 1'b1 && n < 200)
        begin
            @(negedge clk);
            n++;
        end
        `CHK(irq, 1'b1)
        apb(1'b1, offs[0], base | 32'h4);
        repeat (10) @(negedge clk);
        `CHK(irq, 1'b0)
        apb(1'b0, offs[0], 32'h0);
        `CHK(rd[8], 1'b1)
        $display("test interrupt done");
        @(posedge clk);
        gpio <= 44'({$urandom, $urandom});
        apb(1'b1, offs[0], base);
        repeat (3) @(negedge clk);
        `CHK(pad_in_gated, 44'h0)
        v = $urandom & 32'hff;
        c = $urandom;
        s = $urandom & 32'hff;
        apb(1'b1, offs[2], v);
        apb(1'b1, offs[3], c);
        apb(1'b1, offs[4], s);
        apb(1'b1, offs[0], base | 32'h0080_0000);
        repeat (3) @(negedge clk);
        `CHK(seg_switch, {s[7:0], c})
        `CHK(pad_in_gated, gpio & ~{v[3:0], s[7:0], c})
        $display("test pins done");
        apb(1'b1, offs[5], 32'h1);
        apb(1'b1, offs[0], base | 32'h10);
        n = 0;
        do begin @(negedge clk); n++; end
        while (!(com_select[0] && !seg_on[0]) && n < 40000);
        `CHK(seg_on[1], 1'b1)
        n = 0;
        do begin @(negedge clk); n++; end
        while (!(com_select[0] && seg_on[0]) && n < 40000);
        // sub-clock enable comes every second cycle
        `CHK(n, 2 << lcd_seg_pkg::blink_exp_short)
        $display("test blink done");
        final_report;
    end
endmodule
